/* File: rtl/pia_regs.svh */
// register offsets, field positions, widths and reset values of the interrupt arbiter
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

`define PIA_ADDR_W 12
`define PIA_DATA_W 32
`define PIA_PRIO_W 5
`define PIA_ID_W 6
`define PIA_ID_NONE 6'h00
`define PIA_NUM_SRC 32

`define PIA_OFF_ENABLE 12'h000
`define PIA_OFF_THRESH 12'h004
`define PIA_OFF_PENDING 12'h008
`define PIA_OFF_CLAIM 12'h00c
`define PIA_OFF_DELEG 12'h010
`define PIA_OFF_CTX_BUSY 12'h014
`define PIA_OFF_EVT_STS 12'h018
`define PIA_OFF_EVT_MASK 12'h01c
`define PIA_OFF_VEC_BASE 12'h020
`define PIA_OFF_INSERV 12'h024
`define PIA_OFF_PRIO_BASE 12'h080

`define PIA_RST_ENABLE 32'h0000_0000
`define PIA_RST_THRESH 5'h00
`define PIA_RST_DELEG 32'h0000_0000
`define PIA_RST_VEC_BASE 32'h0000_0000
`define PIA_RST_PRIO 5'h00

`define PIA_EVT_W 2
`define PIA_EVT_DISPATCH 0
`define PIA_EVT_EMPTY_CLAIM 1
`define PIA_RST_EVT 2'h0

`define PIA_VEC_SHIFT 2
`define PIA_SRC_SOFT 0
`define PIA_SRC_TIMER 1
`define PIA_SRC_PERIPH 2

`endif

/* File: rtl/pia_pkg.sv */
// types shared by the interrupt arbiter and its users
`include "pia_regs.svh"

package pia_pkg;

    typedef struct packed {
        logic [`PIA_ADDR_W-1:0] addr;
        logic [`PIA_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pia_bus_type;

    typedef struct packed {
        logic mie;
        logic sie;
    } pia_core_en_type;

    typedef struct packed {
        logic req;
        logic [`PIA_ID_W-1:0] id;
        logic [`PIA_DATA_W-1:0] vec;
        logic smode;
    } pia_core_out_type;

endpackage : pia_pkg

/* File: rtl/pia_arb.sv */
// priority picker: highest priority wins, lowest index breaks ties
`timescale 1ns/1ps

module pia_arb #(
    parameter int N = 32,
    parameter int W = 5,
    parameter int IW = $clog2(N)
) (
    input wire logic [N-1:0] valid,
    input wire logic [N-1:0][W-1:0] prio,
    output logic found,
    output logic [IW-1:0] idx,
    output logic [W-1:0] best
);

    always_comb begin
        found = 1'b0;
        idx = '0;
        best = '0;
        // walk downward with >= so the smaller index takes a tie
        for (int i = N - 1; i >= 0; i--) begin
            if (valid[i] && (!found || prio[i] >= best)) begin
                found = 1'b1;
                idx = IW'(i);
                best = prio[i];
            end
        end
    end

endmodule : pia_arb

/* File: rtl/pia_top.sv */
// platform interrupt arbiter: edge sampling, priority arbitration, claim and complete
`timescale 1ns/1ps
`include "pia_regs.svh"

// Notes on behaviour
// [RULE_01] thirty-two interrupt sources are sampled and arbitrated together.
// [RULE_02] source identifiers run from one; zero means nothing is pending.
// [RULE_03] each source has a five-bit priority, 31 highest, 0 lowest, shareable.
// [RULE_04] equal highest priorities resolve to the smaller identifier.
// [RULE_05] a source needs its own enable and the core's private enable.
// [RULE_06] a programmable threshold gates which pending requests reach the core.
// [RULE_07] the core request is a one-cycle pulse carrying only the single winner.
// [RULE_08] a source in service is not requested again until completed.
// [RULE_09] a source becomes pending on a rising edge of its input.
// [RULE_10] each request carries a vector selected by the winning source.
// [RULE_11] higher priority preempts a handler, except during software context save.
// [RULE_12] peripheral, csr software and csr timer lines share one arbitration path.
// [RULE_13] sources delegate to supervisor mode, otherwise target machine mode.
// [RULE_14] a source is forwarded only with priority strictly above the threshold.
// [RULE_15] an edge-latched pending flag holds until the claim clears it.
module pia_top #(
    parameter int NUM_SRC = `PIA_NUM_SRC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input pia_pkg::pia_bus_type bus,
    output logic [`PIA_DATA_W-1:0] rdata,
    input wire logic [NUM_SRC-3:0] periph_irq,
    input wire logic csr_soft_irq,
    input wire logic csr_timer_irq,
    input pia_pkg::pia_core_en_type core_en,
    output pia_pkg::pia_core_out_type core,
    output logic evt_irq
);
    import pia_pkg::*;

    localparam int IW = $clog2(NUM_SRC);
    localparam int PW = `PIA_PRIO_W;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    generate
        if (NUM_SRC < 4 || NUM_SRC > `PIA_NUM_SRC) begin : g_bad_num
            $error("pia_top: NUM_SRC must lie between 4 and 32");
        end
    endgenerate

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [NUM_SRC-1:0] raw_src;
    logic [NUM_SRC-1:0] sync1_q;
    logic [NUM_SRC-1:0] sync2_q;
    logic [NUM_SRC-1:0] prev_q;
    logic [NUM_SRC-1:0] rise;
    logic [NUM_SRC-1:0] pend_q;
    logic [NUM_SRC-1:0] pend_d;
    logic [NUM_SRC-1:0] inserv_q;
    logic [NUM_SRC-1:0] inserv_d;
    logic [NUM_SRC-1:0] enable_q;
    logic [NUM_SRC-1:0] deleg_q;
    logic [NUM_SRC-1:0][PW-1:0] prio_q;
    logic [PW-1:0] thresh_q;
    logic ctx_busy_q;
    logic [`PIA_DATA_W-1:0] vec_base_q;
    logic [`PIA_EVT_W-1:0] evt_sts_q;
    logic [`PIA_EVT_W-1:0] evt_mask_q;
    logic [`PIA_EVT_W-1:0] evt_set;
    logic [`PIA_DATA_W-1:0] rdata_q;
    logic [`PIA_DATA_W-1:0] rdata_d;

    logic [NUM_SRC-1:0] core_ok;
    logic [NUM_SRC-1:0] cand_v;
    logic cand_found;
    logic [IW-1:0] cand_idx;
    logic [PW-1:0] cand_prio;
    logic run_found;
    logic [PW-1:0] run_prio;
    logic [PW-1:0] floor_prio;
    logic win_ok;
    logic [`PIA_ID_W-1:0] win_id;
    logic issued_q;
    logic [`PIA_ID_W-1:0] issued_id_q;
    logic new_win;
    logic req_q;
    logic [`PIA_ID_W-1:0] out_id_q;
    logic [`PIA_DATA_W-1:0] out_vec_q;
    logic out_smode_q;

    logic claim_rd;
    logic complete_wr;
    logic [`PIA_ID_W-1:0] claim_id;
    logic [`PIA_ID_W-1:0] done_id;
    logic [`PIA_ADDR_W-1:0] prio_off;
    logic prio_hit;
    logic [IW-1:0] prio_idx;

    // ----------------------------------------------------------------
    // source sampling
    // ----------------------------------------------------------------
    // csr lines take the lowest identifiers, peripherals follow
    assign raw_src = {periph_irq, csr_timer_irq, csr_soft_irq}; // RULE_12 RULE_01

    // two flops before any logic looks at a pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= raw_src;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q; // RULE_09

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign claim_rd = bus.rd && (bus.addr == `PIA_OFF_CLAIM);
    assign complete_wr = bus.wr && (bus.addr == `PIA_OFF_CLAIM);
    assign done_id = bus.wdata[`PIA_ID_W-1:0];
    assign prio_off = bus.addr - `PIA_OFF_PRIO_BASE;
    assign prio_hit = (bus.addr >= `PIA_OFF_PRIO_BASE)
                   && (prio_off[`PIA_ADDR_W-1:2] < (`PIA_ADDR_W-2)'(NUM_SRC))
                   && (prio_off[1:0] == 2'b00);
    assign prio_idx = prio_off[IW+1:2];

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= NUM_SRC'(`PIA_RST_ENABLE);
            deleg_q <= NUM_SRC'(`PIA_RST_DELEG);
            thresh_q <= `PIA_RST_THRESH;
            ctx_busy_q <= 1'b0;
            vec_base_q <= `PIA_RST_VEC_BASE;
            evt_mask_q <= `PIA_RST_EVT;
        end else if (bus.wr) begin
            unique case (bus.addr)
                `PIA_OFF_ENABLE: enable_q <= bus.wdata[NUM_SRC-1:0]; // RULE_05
                `PIA_OFF_DELEG: deleg_q <= bus.wdata[NUM_SRC-1:0]; // RULE_13
                `PIA_OFF_THRESH: thresh_q <= bus.wdata[PW-1:0]; // RULE_06
                `PIA_OFF_CTX_BUSY: ctx_busy_q <= bus.wdata[0]; // RULE_11
                `PIA_OFF_VEC_BASE: vec_base_q <= bus.wdata;
                `PIA_OFF_EVT_MASK: evt_mask_q <= bus.wdata[`PIA_EVT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // priority store, one word per source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prio_q <= {NUM_SRC{`PIA_RST_PRIO}};
        end else if (bus.wr && prio_hit) begin
            prio_q[prio_idx] <= bus.wdata[PW-1:0]; // RULE_03
        end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    // running priority of the deepest handler sets the preemption floor
    pia_arb #(.N(NUM_SRC), .W(PW)) u_run (
        .valid(inserv_q),
        .prio(prio_q),
        .found(run_found),
        .idx(),
        .best(run_prio)
    );

    always_comb begin
        floor_prio = thresh_q;
        if (run_found && run_prio > thresh_q) begin
            floor_prio = run_prio; // RULE_11
        end
    end

    always_comb begin
        cand_v = '0;
        core_ok = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            // delegated sources answer to the supervisor enable
            core_ok[i] = deleg_q[i] ? core_en.sie : core_en.mie; // RULE_13 RULE_05
            cand_v[i] = pend_q[i] && enable_q[i] && core_ok[i] // RULE_05
                     && !inserv_q[i] // RULE_08
                     && (prio_q[i] > floor_prio); // RULE_14 RULE_06
        end
    end

    pia_arb #(.N(NUM_SRC), .W(PW)) u_cand (
        .valid(cand_v),
        .prio(prio_q),
        .found(cand_found),
        .idx(cand_idx),
        .best(cand_prio)
    ); // RULE_04 RULE_03

    // no dispatch while software saves or restores context
    assign win_ok = cand_found && !ctx_busy_q; // RULE_11
    assign win_id = `PIA_ID_W'(cand_idx) + `PIA_ID_W'(1); // RULE_02

    // pulse only when the winner is new, so a held winner asks once
    assign new_win = win_ok && (!issued_q || win_id != issued_id_q); // RULE_07

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            issued_q <= 1'b0;
            issued_id_q <= `PIA_ID_NONE;
        end else begin
            issued_q <= win_ok;
            issued_id_q <= win_ok ? win_id : `PIA_ID_NONE;
        end
    end

    // ----------------------------------------------------------------
    // request to the core
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= new_win; // RULE_07
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_id_q <= `PIA_ID_NONE;
            out_vec_q <= `PIA_RST_VEC_BASE;
            out_smode_q <= 1'b0;
        end else if (new_win) begin
            out_id_q <= win_id;
            out_vec_q <= vec_base_q + (`PIA_DATA_W'(win_id) << `PIA_VEC_SHIFT); // RULE_10
            out_smode_q <= deleg_q[cand_idx]; // RULE_13
        end
    end

    assign core.req = req_q;
    assign core.id = out_id_q;
    assign core.vec = out_vec_q;
    assign core.smode = out_smode_q;

    // ----------------------------------------------------------------
    // pending and in-service state
    // ----------------------------------------------------------------
    // a claim finding nothing eligible answers zero
    assign claim_id = win_ok ? win_id : `PIA_ID_NONE; // RULE_02

    always_comb begin
        pend_d = pend_q;
        inserv_d = inserv_q;
        if (claim_rd && win_ok) begin
            pend_d[cand_idx] = 1'b0; // RULE_15
            inserv_d[cand_idx] = 1'b1; // RULE_08
        end
        if (complete_wr && done_id != `PIA_ID_NONE && done_id <= `PIA_ID_W'(NUM_SRC)) begin
            inserv_d[IW'(done_id - `PIA_ID_W'(1))] = 1'b0;
        end
        // a fresh edge beats the claim that clears it
        pend_d = pend_d | rise; // RULE_09 RULE_15
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            inserv_q <= '0;
        end else begin
            pend_q <= pend_d;
            inserv_q <= inserv_d;
        end
    end

    // ----------------------------------------------------------------
    // event status and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        evt_set = '0;
        evt_set[`PIA_EVT_DISPATCH] = new_win;
        evt_set[`PIA_EVT_EMPTY_CLAIM] = claim_rd && !win_ok;
    end

    // write one clears, but a same-cycle event keeps its bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_sts_q <= `PIA_RST_EVT;
        end else if (bus.wr && bus.addr == `PIA_OFF_EVT_STS) begin
            evt_sts_q <= (evt_sts_q & ~bus.wdata[`PIA_EVT_W-1:0]) | evt_set;
        end else begin
            evt_sts_q <= evt_sts_q | evt_set;
        end
    end

    assign evt_irq = |(evt_sts_q & evt_mask_q);

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        if (prio_hit) begin
            rdata_d = `PIA_DATA_W'(prio_q[prio_idx]);
        end else begin
            unique case (bus.addr)
                `PIA_OFF_ENABLE: rdata_d = `PIA_DATA_W'(enable_q);
                `PIA_OFF_THRESH: rdata_d = `PIA_DATA_W'(thresh_q);
                `PIA_OFF_PENDING: rdata_d = `PIA_DATA_W'(pend_q);
                `PIA_OFF_CLAIM: rdata_d = `PIA_DATA_W'(claim_id);
                `PIA_OFF_DELEG: rdata_d = `PIA_DATA_W'(deleg_q);
                `PIA_OFF_CTX_BUSY: rdata_d = `PIA_DATA_W'(ctx_busy_q);
                `PIA_OFF_EVT_STS: rdata_d = `PIA_DATA_W'(evt_sts_q);
                `PIA_OFF_EVT_MASK: rdata_d = `PIA_DATA_W'(evt_mask_q);
                `PIA_OFF_VEC_BASE: rdata_d = vec_base_q;
                `PIA_OFF_INSERV: rdata_d = `PIA_DATA_W'(inserv_q);
                default: rdata_d = '0;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= bus.rd ? rdata_d : '0;
        end
    end

    assign rdata = rdata_q;

endmodule : pia_top

/* File: verif/pia_top_sva.sv */
// port checker for the interrupt arbiter
`timescale 1ns/1ps
`include "pia_regs.svh"

module pia_top_sva #(
    parameter int NUM_SRC = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input pia_pkg::pia_bus_type bus,
    input wire logic [`PIA_DATA_W-1:0] rdata,
    input wire logic [NUM_SRC-3:0] periph_irq,
    input wire logic csr_soft_irq,
    input wire logic csr_timer_irq,
    input pia_pkg::pia_core_en_type core_en,
    input pia_pkg::pia_core_out_type core,
    input wire logic evt_irq
);
    import pia_pkg::*;
    // ----
    // properties
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_claim_rd;
        bus.rd && bus.addr == `PIA_OFF_CLAIM;
    endsequence
    sequence s_two_req;
        core.req ##1 core.req;
    endsequence
    a_id_hold: assert property (!core.req |-> $stable(core.id))
        else $error("winner id moved without a pulse");
    a_vec_hold: assert property (!core.req |-> $stable(core.vec) && $stable(core.smode))
        else $error("vector or mode moved without a pulse");
    a_id_range: assert property (core.req |-> core.id != 0 && core.id <= NUM_SRC)
        else $error("request id out of range");
    a_req_gate: assert property (core.req |-> (core.smode ? $past(core_en.sie) : $past(core_en.mie)))
        else $error("request with core enable off");
    a_claim_range: assert property (s_claim_rd |=> rdata <= NUM_SRC)
        else $error("claim read out of range");
    a_req_change: assert property (s_two_req |-> core.id != $past(core.id))
        else $error("same winner pulsed twice");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data outside read slot");
    // loose window: the event bit may land one or two cycles after its cause
    a_evt_cause: assert property ($rose(evt_irq) |-> $past(bus.wr) || $past(bus.rd)
        || $past(bus.rd, 2) || core.req || $past(core.req) || $past(core.req, 2))
        else $error("event line rose without cause");
endmodule : pia_top_sva

/* File: verif/pia_core_model.sv */
// core model that takes the arbiter requests
`timescale 1ns/1ps

module pia_core_model (
    input wire logic mclk,
    input wire logic rst_n,
    input pia_pkg::pia_core_out_type core,
    input pia_pkg::pia_core_en_type en_set,
    output pia_pkg::pia_core_en_type core_en,
    output int n_req,
    output pia_pkg::pia_core_out_type got
);
    import pia_pkg::*;
    // private enables stay on the core side, not in the arbiter
    assign core_en = en_set;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            n_req <= 0;
            got <= '0;
        end else if (core.req) begin
            n_req <= n_req + 1;
            got <= core;
        end
    end
endmodule : pia_core_model

/* File: verif/pia_top_tb_top.sv */
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
`include "pia_regs.svh"

module pia_top_tb_top;
    import pia_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    pia_bus_type bus = '0;
    logic [31:0] src = 32'h0;
    pia_core_en_type en_set = '0;
    pia_core_en_type core_en;
    pia_core_out_type core;
    pia_core_out_type got;
    logic [31:0] rdata;
    logic evt_irq;
    int n_req;
    int seen_n = 0;
    int error_cnt = 0;
    int n_compared = 0;

    always #25 mclk = ~mclk;

    pia_top #(.NUM_SRC(32)) dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .periph_irq(src[31:2]), .csr_soft_irq(src[0]), .csr_timer_irq(src[1]),
        .core_en(core_en), .core(core), .evt_irq(evt_irq));
    pia_core_model u_core (.mclk(mclk), .rst_n(rst_n), .core(core), .en_set(en_set),
        .core_en(core_en), .n_req(n_req), .got(got));

    // ----
    // tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask : rd
    task automatic prio(input int id, input int p);
        wr(`PIA_OFF_PRIO_BASE + 12'(4 * (id - 1)), 32'(p));
    endtask : prio
    // lines stay high three cycles so the synchroniser sees a clean edge
    task automatic fire(input logic [31:0] m);
        @(posedge mclk);
        src <= m;
        repeat (3) @(posedge mclk);
        src <= 32'h0;
    endtask : fire
    task automatic wait_req(input int id, input logic s);
        int k = 0;
        while (n_req == seen_n && k < 40) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk("request arrived", 32'(n_req - seen_n), 32'h1);
        seen_n = n_req;
        chk("request id", 32'(got.id), 32'(id));
        chk("vector", got.vec, 32'h100 + 32'(4 * id));
        chk("mode", 32'(got.smode), 32'(s));
    endtask : wait_req
    task automatic quiet();
        repeat (12) @(posedge mclk);
        #1;
        chk("request count", 32'(n_req), 32'(seen_n));
    endtask : quiet
    task automatic claim(input int id);
        rd(`PIA_OFF_CLAIM, 32'(id), "claim id");
    endtask : claim
    task automatic serve(input int id, input logic s);
        wait_req(id, s);
        claim(id);
        wr(`PIA_OFF_CLAIM, 32'(id));
    endtask : serve
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // ----
    // tests
    // ----
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`PIA_OFF_ENABLE, 32'h0, "enable");
        rd(`PIA_OFF_THRESH, 32'h0, "threshold");
        rd(`PIA_OFF_DELEG, 32'h0, "delegation");
        rd(`PIA_OFF_VEC_BASE, 32'h0, "vector base");
        rd(`PIA_OFF_PENDING, 32'h0, "pending");
        rd(`PIA_OFF_INSERV, 32'h0, "in service");
        rd(`PIA_OFF_EVT_STS, 32'h0, "event status");
        $display("reset test done");
        wr(`PIA_OFF_ENABLE, 32'hffff_ffff);
        wr(`PIA_OFF_VEC_BASE, 32'h100);
        en_set <= '{mie: 1'b1, sie: 1'b0};
        for (int i = 1; i <= 32; i++) begin
            prio(i, 1);
            fire(32'h1 << (i - 1));
            serve(i, 1'b0);
        end
        fire(32'h4);
        wait_req(3, 1'b0);
        rd(`PIA_OFF_PENDING, 32'h4, "pending");
        claim(3);
        rd(`PIA_OFF_PENDING, 32'h0, "pending");
        rd(`PIA_OFF_INSERV, 32'h4, "in service");
        // a fresh edge on a source in service must wait for its completion
        fire(32'h4);
        quiet();
        wr(`PIA_OFF_CLAIM, 32'h3);
        rd(`PIA_OFF_INSERV, 32'h0, "in service");
        serve(3, 1'b0);
        $display("source sweep done");
        prio(1, 7);
        prio(2, 7);
        prio(5, 3);
        fire(32'h13);
        wait_req(1, 1'b0);
        claim(1);
        quiet();
        wr(`PIA_OFF_CLAIM, 32'h1);
        serve(2, 1'b0);
        serve(5, 1'b0);
        fire(32'h10);
        wait_req(5, 1'b0);
        claim(5);
        wr(`PIA_OFF_CTX_BUSY, 32'h1);
        fire(32'h1);
        quiet();
        wr(`PIA_OFF_CTX_BUSY, 32'h0);
        serve(1, 1'b0);
        wr(`PIA_OFF_CLAIM, 32'h5);
        // low source first, higher one a cycle later: two pulses back to back
        @(posedge mclk);
        src <= 32'h10;
        @(posedge mclk);
        src <= 32'h11;
        repeat (8) @(posedge mclk);
        src <= 32'h0;
        #1;
        chk("request count", 32'(n_req - seen_n), 32'h2);
        seen_n = n_req;
        chk("request id", 32'(got.id), 32'h1);
        claim(1);
        wr(`PIA_OFF_CLAIM, 32'h1);
        serve(5, 1'b0);
        $display("priority test done");
        @(posedge mclk);
        src <= 32'h20;
        serve(6, 1'b0);
        quiet();
        src <= 32'h0;
        wr(`PIA_OFF_THRESH, 32'h1);
        fire(32'h8);
        quiet();
        rd(`PIA_OFF_PENDING, 32'h8, "pending");
        prio(4, 2);
        serve(4, 1'b0);
        wr(`PIA_OFF_THRESH, 32'h0);
        wr(`PIA_OFF_ENABLE, 32'hffff_fffb);
        fire(32'h4);
        quiet();
        wr(`PIA_OFF_ENABLE, 32'hffff_ffff);
        serve(3, 1'b0);
        en_set <= '0;
        fire(32'h4);
        quiet();
        wr(`PIA_OFF_DELEG, 32'h4);
        en_set <= '{mie: 1'b0, sie: 1'b1};
        serve(3, 1'b1);
        en_set <= '{mie: 1'b1, sie: 1'b0};
        wr(`PIA_OFF_DELEG, 32'h0);
        $display("gating test done");
        rd(`PIA_OFF_CLAIM, 32'h0, "empty claim");
        rd(`PIA_OFF_EVT_STS, 32'h3, "event status");
        chk("event line", 32'(evt_irq), 32'h0);
        wr(`PIA_OFF_EVT_MASK, 32'h2);
        #1;
        chk("event line", 32'(evt_irq), 32'h1);
        wr(`PIA_OFF_EVT_STS, 32'h2);
        #1;
        chk("event line", 32'(evt_irq), 32'h0);
        rd(`PIA_OFF_EVT_STS, 32'h1, "event status");
        wr(12'h040, 32'h5a5a_5a5a);
        rd(12'h040, 32'h0, "unmapped");
        $display("event test done");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end
endmodule : pia_top_tb_top

bind pia_top pia_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (.mclk(mclk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .periph_irq(periph_irq), .csr_soft_irq(csr_soft_irq),
    .csr_timer_irq(csr_timer_irq), .core_en(core_en), .core(core), .evt_irq(evt_irq));
